// File: design/bcu_chain_unit.sv
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

//Contract
//R01 - shift once per trigger rising edge only
//R02 - clear high zeroes every chain stage; the code does not clear the bank while length or span is bad (cfg_bad)
//R03 - clear overrides trigger, no shift
//R04 - unconnected clear, data, direction read low
//R05 - direction low: shift up, data into base
//R06 - direction high: shift down, data into top
//R07 - output shows last bit shifted out
//R08 - base stage chosen within 0..127
//R09 - length fixed constant 1..128; the code reads length from the cfg register, rewritable at any time
//R10 - bad length: error, output low
//R11 - span past bank end: error, output low
//R12 - out bit is old top/base stage
module bcu_chain_unit (
	// clock and reset
	input  wire logic              clock_in,
	input  wire logic              rst_in,
	// link from surrounding control logic
	input  wire bcu_pkg::bcu_ctl_t ctl_in,
	// register port
	input  wire bcu_pkg::bcu_bus_t bus_in,
	output var  logic [31:0]       rdata_out,
	// results
	output var  logic              chain_out,
	output var  logic              error_out,
	output var  logic              irq_out
);
	import bcu_pkg::*;

	logic               trig_q;
	logic               trig_rise;
	logic               shift_go;
	logic               chain_q;
	logic               error_q;
	logic               irq_q;
	logic [31:0]        rdata_q;
	logic [6:0]         base_q;
	logic [7:0]         len_q;
	logic               sw_clear_q;
	logic [IRQ_W-1:0]   irq_stat_q;
	logic [IRQ_W-1:0]   irq_en_q;
	logic [IRQ_W-1:0]   irq_set;
	logic [127:0]       bank;
	logic               len_bad;
	logic               span_bad;
	logic               cfg_bad;
	logic               clear_any;
	logic [8:0]         top;
	logic               out_bit;

	////////////////////////////////////////////////////////////////////////////////
	// configuration checks
	assign len_bad  = ({1'b0, len_q} < 9'(LEN_MIN)) || ({1'b0, len_q} > 9'(LEN_MAX)); // R10
	assign top      = {2'b00, base_q} + {1'b0, len_q} - 9'h001;
	assign span_bad = ({2'b00, base_q} + {1'b0, len_q}) > 9'(BANK_SIZE); // R11
	assign cfg_bad  = len_bad || span_bad;

	////////////////////////////////////////////////////////////////////////////////
	// trigger edge; inputs are synchronous, one stage of history is enough
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			trig_q <= 1'b0;
		end else begin
			trig_q <= ctl_in.shift_trigger;
		end
	end

	// a level that never toggles causes nothing
	assign trig_rise = ctl_in.shift_trigger && !trig_q; // R01
	// R04: an undriven port is tied low by the integrator, so zero is the idle value
	assign clear_any = ctl_in.clear || sw_clear_q; // R02
	assign shift_go  = trig_rise && !clear_any && !cfg_bad; // R03

	bcu_shift_bank u_bank (
		.clock_in         (clock_in),
		.rst_in           (rst_in),
		.clear_in         (clear_any && !cfg_bad),
		.shift_in         (shift_go),
		.dir_down_in      (ctl_in.dir_down),
		.serial_in_bit_in (ctl_in.serial_in_bit),
		.base_in          (base_q),
		.len_in           (len_q),
		.bank_out         (bank)
	);

	// R12: old content of the far end, picked before the shift lands
	assign out_bit = ctl_in.dir_down ? bank[base_q] : bank[top[6:0]];

	////////////////////////////////////////////////////////////////////////////////
	// output bit
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			chain_q <= 1'b0;
		end else if (cfg_bad) begin
			chain_q <= 1'b0; // R10 R11
		end else if (clear_any) begin
			chain_q <= 1'b0;
		end else if (shift_go) begin
			chain_q <= out_bit; // R07
		end
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			error_q <= 1'b0;
		end else begin
			error_q <= cfg_bad; // R10 R11
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// configuration registers; length is meant to be written once and left alone
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			base_q     <= BASE_RST;
			len_q      <= LEN_RST;
			sw_clear_q <= 1'b0;
		end else if (bus_in.wr) begin
			case (bus_in.addr)
				ADDR_CTRL: begin
					sw_clear_q <= bus_in.wdata[0];
				end
				ADDR_CFG: begin
					base_q <= bus_in.wdata[CFG_BASE_LSB +: 7];
					len_q  <= bus_in.wdata[CFG_LEN_LSB +: 8];
				end
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// interrupts: set beats clear in the same cycle
	assign irq_set[IRQ_SHIFT] = shift_go;
	assign irq_set[IRQ_ERROR] = cfg_bad && !error_q;
	assign irq_set[IRQ_CLEAR] = clear_any;

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			irq_stat_q <= '0;
		end else if (bus_in.wr && bus_in.addr == ADDR_IRQ_CLR) begin
			irq_stat_q <= (irq_stat_q & ~bus_in.wdata[IRQ_W-1:0]) | irq_set;
		end else begin
			irq_stat_q <= irq_stat_q | irq_set;
		end
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			irq_en_q <= '0;
		end else if (bus_in.wr && bus_in.addr == ADDR_IRQ_EN) begin
			irq_en_q <= bus_in.wdata[IRQ_W-1:0];
		end
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |((irq_stat_q | irq_set) & irq_en_q);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read port: data one cycle after the strobe, zero elsewhere
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			rdata_q <= '0;
		end else if (bus_in.rd) begin
			case (bus_in.addr)
				ADDR_CTRL:     rdata_q <= {31'h0000_0000, sw_clear_q};
				ADDR_CFG:      rdata_q <= {16'h0000, len_q, 1'b0, base_q};
				ADDR_STATUS:   rdata_q <= {29'h0000_0000, trig_q, chain_q, error_q};
				ADDR_IRQ_STAT: rdata_q <= {29'h0000_0000, irq_stat_q};
				ADDR_IRQ_EN:   rdata_q <= {29'h0000_0000, irq_en_q};
				4'h8:          rdata_q <= bank[31:0];
				4'h9:          rdata_q <= bank[63:32];
				4'hA:          rdata_q <= bank[95:64];
				4'hB:          rdata_q <= bank[127:96];
				default:       rdata_q <= 32'h0000_0000;
			endcase
		end else begin
			rdata_q <= 32'h0000_0000;
		end
	end

	assign rdata_out = rdata_q;
	assign chain_out = chain_q;
	assign error_out = error_q;
	assign irq_out   = irq_q;

endmodule // bcu_chain_unit

`default_nettype wire

// File: design/bcu_pkg.sv
package bcu_pkg;

	localparam int unsigned BANK_SIZE   = 128;
	localparam int unsigned IDX_W       = 7;
	localparam int unsigned LEN_W       = 8;
	localparam int unsigned LEN_MIN     = 1;
	localparam int unsigned LEN_MAX     = 128;

	// register map of the plain register port
	localparam logic [3:0] ADDR_CTRL     = 4'h0;
	localparam logic [3:0] ADDR_CFG      = 4'h1;
	localparam logic [3:0] ADDR_STATUS   = 4'h2;
	localparam logic [3:0] ADDR_IRQ_STAT = 4'h3;
	localparam logic [3:0] ADDR_IRQ_CLR  = 4'h4;
	localparam logic [3:0] ADDR_IRQ_EN   = 4'h5;
	localparam logic [3:0] ADDR_BANK0    = 4'h8;

	// cfg fields: base in [6:0], length in [15:8]
	localparam int unsigned CFG_BASE_LSB = 0;
	localparam int unsigned CFG_LEN_LSB  = 8;
	localparam logic [6:0]  BASE_RST     = 7'h00;
	localparam logic [7:0]  LEN_RST      = 8'h08;

	// irq bit positions
	localparam int unsigned IRQ_SHIFT    = 0;
	localparam int unsigned IRQ_ERROR    = 1;
	localparam int unsigned IRQ_CLEAR    = 2;
	localparam int unsigned IRQ_W        = 3;

	typedef struct packed {
		logic shift_trigger;
		logic serial_in_bit;
		logic dir_down;
		logic clear;
	} bcu_ctl_t;

	typedef struct packed {
		logic [3:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} bcu_bus_t;

endpackage : bcu_pkg

// File: design/bcu_shift_bank.sv
`timescale 1ns/1ps
`default_nettype none

module bcu_shift_bank (
	// clock and reset
	input  wire logic              clock_in,
	input  wire logic              rst_in,
	// control
	input  wire logic              clear_in,
	input  wire logic              shift_in,
	input  wire logic              dir_down_in,
	input  wire logic              serial_in_bit_in,
	input  wire logic [6:0]        base_in,
	input  wire logic [7:0]        len_in,
	// state
	output var  logic [127:0]      bank_out
);
	import bcu_pkg::*;

	logic [127:0] bank_q;
	logic [127:0] bank_d;
	logic [8:0]   top;

	assign top = {2'b00, base_in} + {1'b0, len_in} - 9'h001;

	////////////////////////////////////////////////////////////////////////////////
	// per-stage next value; only stages inside [base, top] are touched
	for (genvar g = 0; g < BANK_SIZE; g++) begin : g_stage
		logic in_chain;
		logic lo_nb;
		logic hi_nb;
		assign in_chain = (9'(g) >= {2'b00, base_in}) && (9'(g) <= top);
		assign lo_nb    = (g == 0) ? 1'b0 : bank_q[(g == 0) ? 0 : g - 1];
		assign hi_nb    = (g == BANK_SIZE - 1) ? 1'b0 : bank_q[(g == BANK_SIZE - 1) ? g : g + 1];
		always_comb begin
			bank_d[g] = bank_q[g];
			if (in_chain) begin
				if (clear_in) begin
					bank_d[g] = 1'b0; // R02
				end else if (shift_in) begin
					if (!dir_down_in) begin
						// R05
						bank_d[g] = (9'(g) == {2'b00, base_in}) ? serial_in_bit_in : lo_nb;
					end else begin
						// R06
						bank_d[g] = (9'(g) == top) ? serial_in_bit_in : hi_nb;
					end
				end
			end
		end
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			bank_q <= '0;
		end else begin
			bank_q <= bank_d;
		end
	end

	assign bank_out = bank_q;

endmodule // bcu_shift_bank

`default_nettype wire

// File: verif/bcu_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
module bcu_ctl_model (
	// clock and reset
	input  wire logic              clock_in,
	input  wire logic              rst_in,
	// bench commands
	input  wire logic              go_in,
	input  wire logic              bit_in,
	input  wire logic              dir_in,
	input  wire logic              clr_in,
	input  wire logic              slow_in,
	// toward the chain
	output var  bcu_pkg::bcu_ctl_t ctl_out
);
	import bcu_pkg::*;
	logic [3:0] hold_q;
	logic       bit_q;
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			hold_q <= 4'h0;
			bit_q  <= 1'b0;
		end else if (go_in) begin
			hold_q <= slow_in ? 4'h8 : 4'h1;
			bit_q  <= bit_in;
		end else if (hold_q != 4'h0) begin
			hold_q <= hold_q - 4'h1;
		end
	end
	// data only counts at the trigger edge, so between pulses it shows the inverse
	always_comb begin
		ctl_out.shift_trigger = hold_q != 4'h0;
		ctl_out.serial_in_bit = (hold_q != 4'h0) ? bit_q : ~bit_q;
		ctl_out.dir_down      = dir_in;
		ctl_out.clear         = clr_in;
	end
endmodule // bcu_ctl_model
`default_nettype wire

// File: verif/bcu_chain_unit_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module bcu_chain_unit_monitor (
	// clock and reset
	input wire logic              clock_in,
	input wire logic              rst_in,
	// inputs
	input wire bcu_pkg::bcu_ctl_t ctl_in,
	input wire bcu_pkg::bcu_bus_t bus_in,
	// outputs
	input wire logic [31:0]       rdata_out,
	input wire logic              chain_out,
	input wire logic              error_out,
	input wire logic              irq_out
);
	import bcu_pkg::*;
	// software clear as seen from the register port; it is held, so track the last write
	logic sw_clr_q;
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			sw_clr_q <= 1'b0;
		end else if (bus_in.wr && bus_in.addr == ADDR_CTRL) begin
			sw_clr_q <= bus_in.wdata[0];
		end
	end
	default clocking @(posedge clock_in); endclocking
	default disable iff (rst_in);
	a_err_out_low: assert property (error_out && $past(error_out) |-> !chain_out)
		else $error("output high in error");
	a_clear_out_low: assert property ($past(ctl_in.clear, 2) && $past(ctl_in.clear) |-> !chain_out)
		else $error("output high in clear");
	a_sw_clear_low: assert property ($past(sw_clr_q, 2) && $past(sw_clr_q) |-> !chain_out)
		else $error("output high in software clear");
	a_level_no_shift: assert property (!$past(ctl_in.clear) && !$past(sw_clr_q)
		&& !$past(error_out) && !error_out
		&& $past(ctl_in.shift_trigger) == $past(ctl_in.shift_trigger, 2) |-> $stable(chain_out))
		else $error("output moved without edge");
	a_rise_needs_edge: assert property ($rose(chain_out) |-> $past(ctl_in.shift_trigger)
		&& !$past(ctl_in.shift_trigger, 2) && !$past(ctl_in.clear))
		else $error("output rose without edge");
	a_err_after_cfg: assert property ($changed(error_out) |->
		($past(bus_in.wr) && $past(bus_in.addr) == ADDR_CFG)
		|| ($past(bus_in.wr, 2) && $past(bus_in.addr, 2) == ADDR_CFG))
		else $error("error moved without config write");
	a_status_mirror: assert property ($past(bus_in.rd) && $past(bus_in.addr) == ADDR_STATUS
		&& $stable(chain_out) && $stable(error_out) |-> rdata_out[1:0] == {chain_out, error_out})
		else $error("status read wrong");
	a_rdata_idle: assert property (!$past(bus_in.rd) |-> rdata_out == 32'h0000_0000)
		else $error("read data outside read");
	a_clr_reads_zero: assert property ($past(bus_in.rd) && $past(bus_in.addr) == ADDR_IRQ_CLR
		|-> rdata_out == 32'h0000_0000)
		else $error("clear register not zero");
endmodule // bcu_chain_unit_monitor
`default_nettype wire

// File: verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import bcu_pkg::*;
	logic        clock_in, rst_in, go, sb, dir, clr, slow, chain, err, irq;
	bcu_bus_t    bus;
	bcu_ctl_t    ctl;
	logic [31:0] rdata;
	logic [16:0] tbl [7] = '{17'h0_017f, 17'h1_027f, 17'h0_8000, 17'h1_0000,
		17'h1_8001, 17'h1_8100, 17'h0_0878};
	int          failures = 0, n_tests = 0, cyc = 0;
	bcu_ctl_model u_ctl (.clock_in, .rst_in, .go_in(go), .bit_in(sb), .dir_in(dir),
		.clr_in(clr), .slow_in(slow), .ctl_out(ctl));
	bcu_chain_unit dut (.clock_in, .rst_in, .ctl_in(ctl), .bus_in(bus), .rdata_out(rdata),
		.chain_out(chain), .error_out(err), .irq_out(irq));
	task automatic results();
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock_in) bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clock_in) bus <= '0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		@(posedge clock_in) bus <= '{a, 32'h0000_0000, 1'b0, 1'b1};
		@(posedge clock_in) bus <= '0;
		@(negedge clock_in) chk(rdata, exp);
	endtask
	task automatic sh(input logic b, input logic d, input logic s);
		@(posedge clock_in) {go, sb, dir, slow} <= {1'b1, b, d, s};
		@(posedge clock_in) go <= 1'b0;
		repeat (12) @(posedge clock_in);
	endtask
	////////////////////////////////////////
	initial begin
		clock_in = 1'b0;
		forever #5 clock_in = ~clock_in;
	end
	always @(posedge clock_in) begin
		cyc++;
		if (cyc > 5000) begin
			failures++;
			results();
		end
	end
	initial begin
		rst_in = 1'b1;
		bus = '0;
		{go, sb, dir, clr, slow} = '0;
		repeat (5) @(posedge clock_in);
		rst_in <= 1'b0;
		rd(ADDR_CFG, 32'h0000_0800);
		rd(ADDR_STATUS, 32'h0000_0000);
		for (int i = 0; i < 9; i++) sh(i inside {0, 2, 3}, 1'b0, 1'b0);
		chk(32'(chain), 32'h0000_0001);
		rd(ADDR_BANK0, 32'h0000_0060);
		sh(1'b1, 1'b1, 1'b0);
		chk(32'(chain), 32'h0000_0000);
		rd(ADDR_BANK0, 32'h0000_00b0);
		for (int i = 0; i < 5; i++) sh(1'b0, 1'b1, 1'b0);
		chk(32'(chain), 32'h0000_0001);
		rd(ADDR_BANK0, 32'h0000_0005);
		@(posedge clock_in) clr <= 1'b1;
		sh(1'b1, 1'b0, 1'b0);
		chk(32'(chain), 32'h0000_0000);
		rd(ADDR_BANK0, 32'h0000_0000);
		@(posedge clock_in) clr <= 1'b0;
		sh(1'b1, 1'b0, 1'b1);
		rd(ADDR_BANK0, 32'h0000_0001);
		wr(ADDR_IRQ_EN, 32'h0000_0001);
		rd(ADDR_IRQ_STAT, 32'h0000_0005);
		chk(32'(irq), 32'h0000_0001);
		wr(ADDR_IRQ_CLR, 32'h0000_0007);
		rd(ADDR_IRQ_STAT, 32'h0000_0000);
		chk(32'(irq), 32'h0000_0000);
		rd(ADDR_IRQ_CLR, 32'h0000_0000);
		sh(1'b0, 1'b0, 1'b0);
		chk(32'(irq), 32'h0000_0001);
		wr(ADDR_IRQ_EN, 32'h0000_0000);
		rd(4'hf, 32'h0000_0000);
		chk(32'(irq), 32'h0000_0000);
		foreach (tbl[i]) begin
			wr(ADDR_CFG, {16'h0000, tbl[i][15:0]});
			rd(ADDR_CFG, {16'h0000, tbl[i][15:0]});
			chk(32'(err), 32'(tbl[i][16]));
			sh(1'b1, 1'b0, 1'b0);
			if (tbl[i][16]) chk(32'(chain), 32'h0000_0000);
		end
		rd(ADDR_BANK0, 32'h0000_0005);
		rd(4'hb, 32'h0100_0000);
		sh(1'b1, 1'b1, 1'b0);
		chk(32'(chain), 32'h0000_0001);
		rd(4'hb, 32'h8000_0000);
		wr(ADDR_CTRL, 32'h0000_0001);
		rd(ADDR_CTRL, 32'h0000_0001);
		chk(32'(chain), 32'h0000_0000);
		sh(1'b1, 1'b0, 1'b0);
		chk(32'(chain), 32'h0000_0000);
		rd(4'hb, 32'h0000_0000);
		wr(ADDR_CTRL, 32'h0000_0000);
		rd(ADDR_IRQ_STAT, 32'h0000_0007);
		results();
	end
endmodule // tb
bind bcu_chain_unit bcu_chain_unit_monitor u_mon (.clock_in, .rst_in, .ctl_in, .bus_in,
	.rdata_out, .chain_out, .error_out, .irq_out);
`default_nettype wire
